// >>> reset_cause_top.sv
// Reset source combiner with retained cause flags and hibernate data
`timescale 1ns/1ps
`include "reset_cause_params.svh"

module reset_cause_top
  import reset_cause_pkg::*;
#(
  // Number of fast clocks actually present
  parameter int FAST_CLK_IMPL = 16
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         external_reset_pin_n_i,
  input  wire logic                         digital_supply_good_i,
  input  wire logic                         brownout_reset_i,
  input  wire logic                         hw_watchdog_req_i,
  input  wire logic [`MCWDT_NUM-1:0]        mc_watchdog_req_i,
  input  wire logic                         small_core_ctl_wr_i,
  input  wire logic [`APP_KEY_W-1:0]        small_core_key_i,
  input  wire logic                         small_core_sysreq_i,
  input  wire logic                         main_core_ctl_wr_i,
  input  wire logic [`APP_KEY_W-1:0]        main_core_key_i,
  input  wire logic                         main_core_sysreq_i,
  input  wire logic                         prot_fault_req_i,
  input  reset_cause_pkg::power_mode_e      power_mode_i,
  input  wire logic                         xtal_sup_en_i,
  input  wire logic                         xtal_loss_req_i,
  input  wire logic [`FAST_CLK_NUM-1:0]     fast_loss_req_i,
  input  wire logic [`FAST_CLK_NUM-1:0]     fast_freq_req_i,
  input  wire logic                         hib_wakeup_req_i,
  input  wire logic                         cause_clr_wr_i,
  input  wire logic [`CAUSE_W-1:0]          cause_clr_i,
  input  wire logic                         cause2_clr_wr_i,
  input  wire logic [`CAUSE2_W-1:0]         cause2_clr_i,
  input  wire logic                         token_wr_i,
  input  wire logic [`TOKEN_W-1:0]          token_wdata_i,
  input  wire logic                         hib_data_wr_i,
  input  wire logic [`HIB_DATA_W-1:0]       hib_data_wdata_i,
  output logic                              sys_reset_n_o,
  output logic                              retention_lost_o,
  output logic [`CAUSE_W-1:0]               reset_cause_register_o,
  output logic [`CAUSE2_W-1:0]              reset_cause_second_o,
  output logic [`TOKEN_W-1:0]               hib_token_o,
  output logic [`HIB_DATA_W-1:0]            hibernate_retained_data_o
);

  // Pin and monitor synchronisers, first stage read only by second
  logic       pin_meta_r;
  logic       pin_sync_r;
  logic       pgood_meta_r;
  logic       pgood_sync_r;
  logic       brown_meta_r;
  logic       brown_sync_r;

  seq_state_e state_r;
  seq_state_e state_nxt;
  logic [3:0] stretch_r;
  logic [3:0] stretch_nxt;
  logic       sys_reset_n_nxt;

  logic [`CAUSE_W-1:0]  cause_set;
  logic [`CAUSE_W-1:0]  cause_clr;
  logic [`CAUSE_W-1:0]  cause_flags;
  logic [`CAUSE2_W-1:0] cause2_set;
  logic [`CAUSE2_W-1:0] cause2_clr;
  logic [`CAUSE2_W-1:0] cause2_flags;
  logic [`FAST_CLK_NUM-1:0] impl_mask;

  // Two flops on every asynchronous level; pin idles high
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_meta_r   <= 1'b1;
      pin_sync_r   <= 1'b1;
      pgood_meta_r <= 1'b0;
      pgood_sync_r <= 1'b0;
      brown_meta_r <= 1'b0;
      brown_sync_r <= 1'b0;
    end else begin
      pin_meta_r   <= external_reset_pin_n_i;
      pin_sync_r   <= pin_meta_r;
      pgood_meta_r <= digital_supply_good_i;
      pgood_sync_r <= pgood_meta_r;
      brown_meta_r <= brownout_reset_i;
      brown_sync_r <= brown_meta_r;
    end
  end

  // Retention-loss sources: pin, supply not yet good, brownout
  wire pin_active;
  wire por_active;
  wire ret_lost;
  assign pin_active  = ~pin_sync_r;
  assign por_active  = ~pgood_sync_r;
  assign ret_lost    = pin_active | por_active | brown_sync_r;

  // Core requests count only with the right key in the same write
  wire small_req;
  wire main_req;
  wire soft_req;
  assign small_req = small_core_ctl_wr_i & small_core_sysreq_i &
                     (small_core_key_i == `APP_KEY_VAL);
  assign main_req  = main_core_ctl_wr_i & main_core_sysreq_i &
                     (main_core_key_i == `APP_KEY_VAL);
  assign soft_req  = small_req | main_req;

  // Recordable sources, each pulse-captured as it asserts
  wire fault_req;
  wire xtal_req;
  wire dog_any;
  assign fault_req = prot_fault_req_i;
  assign xtal_req  = xtal_sup_en_i & xtal_loss_req_i;
  assign dog_any   = hw_watchdog_req_i | (|mc_watchdog_req_i);

  assign impl_mask = (FAST_CLK_IMPL >= `FAST_CLK_NUM) ? {`FAST_CLK_NUM{1'b1}}
                   : `FAST_CLK_NUM'((17'h1 << FAST_CLK_IMPL) - 17'h1);

  // Flag set vector; nothing for POR, brownout, pin or wakeup
  // Watchdog, fault, crystal and soft reset flags
  always_comb begin
    cause_set = `CAUSE_RST_VAL;
    cause_set[`CAUSE_HW_DOG_BIT] = hw_watchdog_req_i;
    cause_set[`CAUSE_ACT_FLT_BIT] = fault_req & (power_mode_i == MODE_ACTIVE);
    cause_set[`CAUSE_DS_FLT_BIT] = fault_req &
                                   (power_mode_i == MODE_DEEPSLEEP);
    cause_set[`CAUSE_XTAL_BIT] = xtal_req;
    cause_set[`CAUSE_SOFT_BIT] = soft_req;
    cause_set[`CAUSE_MCWDT_LSB +: `MCWDT_NUM] = mc_watchdog_req_i;
  end

  assign cause2_set = {fast_freq_req_i & impl_mask,
                       fast_loss_req_i & impl_mask};

  assign cause_clr  = cause_clr_wr_i  ? cause_clr_i  : `CAUSE_RST_VAL;
  assign cause2_clr = cause2_clr_wr_i ? cause2_clr_i : `CAUSE2_RST_VAL;

  sticky_flag #(.W(`CAUSE_W)) u_cause (
    .clk_i            (clk_i),
    .retention_lost_i (ret_lost),
    .set_i            (cause_set),
    .clr_i            (cause_clr),
    .flag_o           (cause_flags)
  );

  sticky_flag #(.W(`CAUSE2_W)) u_cause2 (
    .clk_i            (clk_i),
    .retention_lost_i (ret_lost),
    .set_i            (cause2_set),
    .clr_i            (cause2_clr),
    .flag_o           (cause2_flags)
  );

  // Any request that brings the system down
  wire any_req;
  wire hold_now;
  assign any_req = dog_any | soft_req | fault_req | xtal_req |
                   (|cause2_set) | hib_wakeup_req_i;
  assign hold_now = ret_lost | any_req;

  // Sequencer: hold, stretch a few cycles, then run
  // Stretch lets short requests still give a clean reset pulse
  always_comb begin
    state_nxt       = state_r;
    stretch_nxt     = stretch_r;
    sys_reset_n_nxt = 1'b0;
    case (state_r)
      SEQ_HOLD: begin
        if (!hold_now) begin
          state_nxt   = SEQ_STRETCH;
          stretch_nxt = `RST_STRETCH_CYC;
        end
      end
      SEQ_STRETCH: begin
        if (hold_now) begin
          state_nxt = SEQ_HOLD;
        end else if (stretch_r == 4'h1) begin
          state_nxt       = SEQ_RUN;
          sys_reset_n_nxt = 1'b1;
        end else begin
          stretch_nxt = stretch_r - 4'h1;
        end
      end
      SEQ_RUN: begin
        sys_reset_n_nxt = 1'b1;
        if (hold_now) begin
          state_nxt       = SEQ_HOLD;
          sys_reset_n_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = SEQ_HOLD;
      end
    endcase
  end

  // Block's own reset is power-on of this logic only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r       <= SEQ_HOLD;
      stretch_r     <= 4'h0;
      sys_reset_n_o <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      stretch_r     <= stretch_nxt;
      sys_reset_n_o <= sys_reset_n_nxt;
    end
  end

  // Registered copies of cause flags and retention status
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      retention_lost_o       <= 1'b1;
      reset_cause_register_o <= `CAUSE_RST_VAL;
      reset_cause_second_o   <= `CAUSE2_RST_VAL;
    end else begin
      retention_lost_o       <= ret_lost;
      reset_cause_register_o <= cause_flags;
      reset_cause_second_o   <= cause2_flags;
    end
  end

  // Token survives wakeup and system reset; retained data survives wakeup but pin reset clears it
  // Token retained
  // No backup-domain reset output exists here
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || por_active || brown_sync_r) begin
      hib_token_o               <= 8'h00;
      hibernate_retained_data_o <= 32'h0000_0000;
    end else begin
      if (pin_active) begin
        hibernate_retained_data_o <= 32'h0000_0000;
      end else if (hib_data_wr_i) begin
        hibernate_retained_data_o <= hib_data_wdata_i;
      end
      if (token_wr_i && !pin_active) begin
        hib_token_o <= token_wdata_i;
      end
    end
  end

endmodule : reset_cause_top

// >>> reset_cause_params.svh
// Constants for the reset source and cause logic
`ifndef RESET_CAUSE_PARAMS_SVH
`define RESET_CAUSE_PARAMS_SVH

// Key that must accompany a core reset request
`define APP_KEY_VAL        16'h05FA
`define APP_KEY_W          16
// Cause register bit positions
`define CAUSE_HW_DOG_BIT   0
`define CAUSE_ACT_FLT_BIT  1
`define CAUSE_DS_FLT_BIT   2
`define CAUSE_XTAL_BIT     3
`define CAUSE_SOFT_BIT     4
`define CAUSE_MCWDT_LSB    5
`define CAUSE_W            9
`define CAUSE_RST_VAL      9'h000
// Second cause register layout
`define CAUSE2_FREQ_LSB    16
`define CAUSE2_W           32
`define CAUSE2_RST_VAL     32'h0000_0000
`define FAST_CLK_NUM       16
`define MCWDT_NUM          4
`define TOKEN_W            8
`define HIB_DATA_W         32
// Cycles the system reset stays asserted after the last request drops
`define RST_STRETCH_CYC    4'h8

`endif

// >>> reset_cause_pkg.sv
// Types shared by the reset source and cause logic
package reset_cause_pkg;
  // Reset sequencing states
  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_STRETCH,
    SEQ_RUN
  } seq_state_e;

  // Power mode seen when a protection fault fires
  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_DEEPSLEEP,
    MODE_OTHER
  } power_mode_e;
endpackage : reset_cause_pkg

// >>> sticky_flag.sv
// Sticky cause flag with set priority and write-one clear
`timescale 1ns/1ps
module sticky_flag #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         retention_lost_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flag_o
);
  logic [W-1:0] flag_nxt;

  // Set wins over a clear in the same cycle; only retention loss wipes
  assign flag_nxt = (flag_o & ~clr_i) | set_i;

  // Kept through ordinary system resets on purpose
  always_ff @(posedge clk_i) begin
    if (retention_lost_i) begin
      flag_o <= '0;
    end else begin
      flag_o <= flag_nxt;
    end
  end
endmodule : sticky_flag

// >>> reset_cause_sva.sv
// Assertion checker for the reset source and cause logic
`timescale 1ns/1ps
`include "reset_cause_params.svh"
module reset_cause_sva
  import reset_cause_pkg::*;
#(
  parameter int FAST_CLK_IMPL = 16
) (
  input wire logic                     clk_i,
  input wire logic                     rst_n_i,
  input wire logic                     external_reset_pin_n_i,
  input wire logic                     hw_watchdog_req_i,
  input wire logic [`MCWDT_NUM-1:0]    mc_watchdog_req_i,
  input wire logic                     small_core_ctl_wr_i,
  input wire logic [`APP_KEY_W-1:0]    small_core_key_i,
  input wire logic                     small_core_sysreq_i,
  input wire logic                     main_core_ctl_wr_i,
  input wire logic [`APP_KEY_W-1:0]    main_core_key_i,
  input wire logic                     main_core_sysreq_i,
  input wire logic                     prot_fault_req_i,
  input reset_cause_pkg::power_mode_e  power_mode_i,
  input wire logic                     hib_wakeup_req_i,
  input wire logic                     cause_clr_wr_i,
  input wire logic [`CAUSE_W-1:0]      cause_clr_i,
  input wire logic                     token_wr_i,
  input wire logic                     sys_reset_n_o,
  input wire logic                     retention_lost_o,
  input wire logic [`CAUSE_W-1:0]      reset_cause_register_o,
  input wire logic [`CAUSE2_W-1:0]     reset_cause_second_o,
  input wire logic [`TOKEN_W-1:0]      hib_token_o,
  input wire logic [`HIB_DATA_W-1:0]   hibernate_retained_data_o
);
  // Keyed core writes and the requests that must reset at once
  wire sw_ok = (small_core_ctl_wr_i && small_core_sysreq_i
    && small_core_key_i == `APP_KEY_VAL) || (main_core_ctl_wr_i
    && main_core_sysreq_i && main_core_key_i == `APP_KEY_VAL);
  wire any_req = sw_ok | hw_watchdog_req_i | (|mc_watchdog_req_i)
    | prot_fault_req_i | hib_wakeup_req_i;
  wire [15:0] impl_m = 16'hFFFF >> (16 - FAST_CLK_IMPL);
  wire ret_n = !retention_lost_o;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Pin seen low through both sync stages
  sequence pin_held;
    (!external_reset_pin_n_i) [*3];
  endsequence
  sequence stretch;
    (!sys_reset_n_o) [*8];
  endsequence

  a_pin_resets: assert property (pin_held |=> !sys_reset_n_o)
    else $error("pin low did not reset");
  a_pin_data_clr: assert property (pin_held |-> ##[1:3]
    hibernate_retained_data_o == '0) else $error("data kept");
  a_req_resets: assert property (any_req |=> stretch)
    else $error("reset not held after request");
  a_soft_flag: assert property (sw_ok && ret_n |-> ##2
    reset_cause_register_o[`CAUSE_SOFT_BIT]) else $error("no soft flag");
  a_dog_flag: assert property (hw_watchdog_req_i && ret_n |-> ##2
    reset_cause_register_o[`CAUSE_HW_DOG_BIT])
    else $error("no watchdog flag");
  a_fault_flag: assert property (prot_fault_req_i && ret_n &&
    power_mode_i == MODE_DEEPSLEEP |-> ##2
    reset_cause_register_o[`CAUSE_DS_FLT_BIT]) else $error("no ds flag");
  a_flags_sticky: assert property (!$past(cause_clr_wr_i) && ret_n
    && !$past(retention_lost_o) |=> (reset_cause_register_o
    & $past(reset_cause_register_o)) == $past(reset_cause_register_o))
    else $error("flag dropped");
  a_clear_one: assert property (cause_clr_wr_i && cause_clr_i[4]
    && !sw_ok |-> ##2 !reset_cause_register_o[4]) else $error("no clear");
  a_retention_clr: assert property (retention_lost_o |=>
    reset_cause_register_o == '0 && reset_cause_second_o == '0)
    else $error("flags survive retention loss");
  a_unimpl_zero: assert property ((reset_cause_second_o
    & ~{impl_m, impl_m}) == '0) else $error("absent clock bit set");
  a_token_kept: assert property (!token_wr_i && ret_n ##1 ret_n
    |-> $stable(hib_token_o)) else $error("token changed");
endmodule : reset_cause_sva

bind reset_cause_top reset_cause_sva #(.FAST_CLK_IMPL(FAST_CLK_IMPL)) chk (.*);

// >>> far_side_model.sv
// Far side model: reset pin with pull-up and supply monitors
`timescale 1ns/1ps
module far_side_model (
  input  wire logic pin_drv_en_n_i,
  input  wire logic supply_up_i,
  input  wire logic sag_i,
  output logic      pin_n_o,
  output logic      supply_good_o,
  output logic      brownout_o
);
  // Pin pulled high inside, so a released pin reads one
  assign pin_n_o = pin_drv_en_n_i ? 1'b1 : 1'b0;
  // A sag drops the good level and raises the brownout
  assign supply_good_o = supply_up_i & ~sag_i;
  assign brownout_o = supply_up_i & sag_i;
endmodule : far_side_model

// >>> tb_top.sv
// Self-checking bench for the reset source and cause logic
`timescale 1ns/1ps
`include "reset_cause_params.svh"
module tb_top;
  import reset_cause_pkg::*;
  localparam int IMPL = 12;
  logic        clk_i, rst_n_i, pin_en_n, sup_up, sag, pin_n, sup_ok, brn;
  logic        hw_dog, s_wr, m_wr, s_req, m_req, prot, xen, xloss, hib;
  logic        c_wr, c2_wr, t_wr, d_wr, sys_n, ret;
  logic [3:0]  mcw;
  logic [15:0] s_key, m_key, floss, ffreq;
  logic [8:0]  c_clr, cause, exp_c;
  logic [31:0] c2_clr, d_wd, cause2, hdata;
  logic [7:0]  t_wd, token;
  power_mode_e mode;
  int          n_fail = 0;
  int          num_checks = 0;

  far_side_model fs (.pin_drv_en_n_i(pin_en_n), .supply_up_i(sup_up),
    .sag_i(sag), .pin_n_o(pin_n), .supply_good_o(sup_ok), .brownout_o(brn));
  reset_cause_top #(.FAST_CLK_IMPL(IMPL)) dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .external_reset_pin_n_i(pin_n),
    .digital_supply_good_i(sup_ok), .brownout_reset_i(brn),
    .hw_watchdog_req_i(hw_dog), .mc_watchdog_req_i(mcw),
    .small_core_ctl_wr_i(s_wr), .small_core_key_i(s_key),
    .small_core_sysreq_i(s_req), .main_core_ctl_wr_i(m_wr),
    .main_core_key_i(m_key), .main_core_sysreq_i(m_req),
    .prot_fault_req_i(prot), .power_mode_i(mode), .xtal_sup_en_i(xen),
    .xtal_loss_req_i(xloss), .fast_loss_req_i(floss),
    .fast_freq_req_i(ffreq), .hib_wakeup_req_i(hib),
    .cause_clr_wr_i(c_wr), .cause_clr_i(c_clr), .cause2_clr_wr_i(c2_wr),
    .cause2_clr_i(c2_clr), .token_wr_i(t_wr), .token_wdata_i(t_wd),
    .hib_data_wr_i(d_wr), .hib_data_wdata_i(d_wd), .sys_reset_n_o(sys_n),
    .retention_lost_o(ret), .reset_cause_register_o(cause),
    .reset_cause_second_o(cause2), .hib_token_o(token),
    .hibernate_retained_data_o(hdata));

  // Free-running clock, 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Inputs move 1 ns after the edge, clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // Wide enough for every concatenated compare below
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // Bounded wait for the system to leave reset
  task automatic wait_up();
    for (int i = 0; sys_n !== 1'b1; i++) begin
      if (i == 100) begin
        n_fail++;
        end_sim();
      end
      step(1);
    end
  endtask : wait_up
  // Firmware write-one clear of both cause registers
  task automatic clr(input logic [8:0] m, input logic [31:0] m2);
    c_clr = m;
    c2_clr = m2;
    c_wr = 1'b1;
    c2_wr = 1'b1;
    step(1);
    c_wr = 1'b0;
    c2_wr = 1'b0;
    step(2);
  endtask : clr
  // One-cycle pulse of source k; 12 bad key, 13 no request bit,
  // 14 crystal loss with its supervisor switched off
  task automatic fire(input int k);
    mode = (k == 2) ? MODE_DEEPSLEEP : (k == 10) ? MODE_OTHER : MODE_ACTIVE;
    s_key = (k == 12) ? 16'h05FB : `APP_KEY_VAL;
    m_req = (k != 13);
    xen = (k != 14);
    case (k)
      0: hw_dog = 1'b1;
      1, 2, 10: prot = 1'b1;
      3, 14: xloss = 1'b1;
      4, 12: s_wr = 1'b1;
      5, 13: m_wr = 1'b1;
      11: hib = 1'b1;
      default: mcw = 4'h1 << (k - 6);
    endcase
    step(1);
    {hw_dog, prot, xloss, s_wr, m_wr, hib, mcw} = '0;
  endtask : fire
  function automatic logic [8:0] flag_of(input int k);
    case (k)
      0, 1, 2, 3: return 9'h001 << k;
      4, 5: return 9'h001 << `CAUSE_SOFT_BIT;
      6, 7, 8, 9: return 9'h001 << (k - 1);
      default: return 9'h000;
    endcase
  endfunction : flag_of

  // Main sequence
  initial begin
    {rst_n_i, sup_up, sag, hw_dog, s_wr, m_wr, prot, hib, xloss} = '0;
    {c_wr, c2_wr, t_wr, d_wr, mcw, floss, ffreq, c_clr, c2_clr} = '0;
    {pin_en_n, s_req, m_req, xen} = 4'hF;
    s_key = `APP_KEY_VAL;
    m_key = `APP_KEY_VAL;
    t_wd = 8'hA5;
    d_wd = 32'h1234_5678;
    mode = MODE_ACTIVE;
    step(5);
    rst_n_i = 1'b1;
    step(4);
    chk(sys_n, 1'b0);
    sup_up = 1'b1;
    wait_up();
    chk({ret, cause2, cause}, '0);
    $display("test power_up done");
    exp_c = 9'h000;
    for (int k = 0; k < 15; k++) begin
      fire(k);
      chk(sys_n, k > 11);
      wait_up();
      exp_c = exp_c | flag_of(k);
      chk(cause, exp_c);
    end
    clr(9'h010, 32'h0);
    chk(cause, exp_c & 9'h1EF);
    // Clear and set of one flag in the same cycle: the set must win
    c_clr = 9'h001;
    c_wr = 1'b1;
    fire(0);
    c_wr = 1'b0;
    wait_up();
    chk(cause, exp_c & 9'h1EF);
    $display("test sources done");
    floss = 16'hFFFF;
    ffreq = 16'h8001;
    step(1);
    {floss, ffreq} = '0;
    wait_up();
    chk(cause2, 32'h0001_0FFF);
    clr(9'h1FF, 32'hFFFF_FFFF);
    chk({cause2, cause}, '0);
    $display("test fast_clocks done");
    t_wr = 1'b1;
    d_wr = 1'b1;
    step(1);
    {t_wr, d_wr} = '0;
    fire(11);
    wait_up();
    chk({token, hdata}, {8'hA5, 32'h1234_5678});
    fire(0);
    wait_up();
    pin_en_n = 1'b0;
    step(6);
    chk({sys_n, cause, hdata}, '0);
    chk(ret, 1'b1);
    pin_en_n = 1'b1;
    wait_up();
    chk(token, 8'hA5);
    fire(4);
    wait_up();
    sag = 1'b1;
    step(6);
    chk({sys_n, cause}, '0);
    chk(ret, 1'b1);
    sag = 1'b0;
    wait_up();
    $display("test retention done");
    end_sim();
  end
endmodule : tb_top
